// ==== dv/bit_set_skip_branch_exec_tb.sv ====
// Self-checking bench for bit set, bit test with skip and relative jump.
// Assumes regfile_model answers the register port; the bench plays the fetch path.
`timescale 1ns/1ns
`default_nettype none

module bit_set_skip_branch_exec_tb;
	logic                    clk;
	logic                    srst;
	logic [15:0]             instr;
	logic [1:0]              next_words;
	logic [20:0]             pc_in;
	logic                    discard_fetch;
	logic                    pc_load;
	logic [20:0]             pc_target;
	logic                    busy;
	logic [5:0]              bank_choice_value;
	logic                    ext_set_en;
	logic [13:0]             index_base;
	logic [7:0]              rd_data;
	bit_exec_pkg::data_req_t data_req;
	bit_exec_pkg::phase_t    phase;
	int                      errors;
	int                      samples_checked;
	int                      n_rd;
	int                      n_wr;
	int                      n_pl;
	int                      n_dis;
	int                      n_busy;
	logic [13:0]             wr_addr;
	logic [7:0]              wr_data;
	logic                    wr_idx;

	bit_set_skip_branch_exec u_dut (.clk(clk), .srst(srst), .instr(instr),
		.next_words(next_words), .pc_in(pc_in), .discard_fetch(discard_fetch),
		.pc_load(pc_load), .pc_target(pc_target), .busy(busy),
		.bank_choice_value(bank_choice_value), .ext_set_en(ext_set_en),
		.index_base(index_base), .data_req(data_req), .rd_data(rd_data), .phase(phase));
	regfile_model u_mem (.clk(clk), .data_req(data_req), .rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// One instruction, then a tally of every strobe over 18 clocks
	// ------------------------------------------------------------
	task automatic run(input logic [15:0] word, input logic [1:0] nw);
		int k;
		k = 0;
		while (!(phase === bit_exec_pkg::PH_Q1 && busy === 1'b0) && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		check("ready for instr", {phase, busy}, {bit_exec_pkg::PH_Q1, 1'b0});
		instr = word;
		next_words = nw;
		n_rd = 0;
		n_wr = 0;
		n_pl = 0;
		n_dis = 0;
		n_busy = 0;
		for (int c = 0; c < 18; c++) begin
			@(posedge clk);
			#1;
			instr = 16'h0000;
			n_rd += int'(data_req.rd === 1'b1);
			n_pl += int'(pc_load === 1'b1);
			n_dis += int'(discard_fetch === 1'b1);
			n_busy += int'(busy === 1'b1);
			if (data_req.wr === 1'b1) begin
				n_wr++;
				wr_addr = data_req.addr;
				wr_data = data_req.wdata;
				wr_idx = data_req.indexed;
			end
		end
	endtask : run

	task automatic t_set_bank();
		logic [7:0]  fs [4] = '{8'h20, 8'h20, 8'h60, 8'h5F};
		logic        as [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
		logic [13:0] ea [4] = '{14'h0520, 14'h0020, 14'h3F60, 14'h015F};
		for (int i = 0; i < 4; i++) begin
			ext_set_en = (i >= 2);
			u_mem.mem[ea[i]] = 8'h0A;
			run({4'h8, 3'h7, as[i], fs[i]}, 2'h1);
			check("set reads", n_rd, 1);
			check("set writes", n_wr, 1);
			check("set addr", wr_addr, ea[i]);
			check("set indexed", wr_idx, i == 3);
			check("set data", wr_data, 8'h8A);
			check("set busy", n_busy, 0);
		end
		ext_set_en = 1'b0;
	endtask : t_set_bank

	task automatic t_skip();
		u_mem.mem[14'h0520] = 8'h08;
		for (int k = 0; k < 4; k++) begin
			run({4'hB, 3'h4, 1'b1, 8'h20}, k[1:0]);
			check("skip discard", n_dis, 1);
			check("skip busy", n_busy, 4 * ((k == 0) ? 1 : k));
			check("skip writes", n_wr, 0);
		end
		run({4'hB, 3'h3, 1'b1, 8'h20}, 2'h3);
		check("noskip discard", n_dis, 0);
		check("noskip busy", n_busy, 0);
		check("noskip reads", n_rd, 1);
	endtask : t_skip

	task automatic t_jump();
		logic [10:0] offs [3] = '{11'h400, 11'h3FF, 11'h7FD};
		for (int i = 0; i < 3; i++) begin
			run({5'h1A, offs[i]}, 2'h1);
			check("jump load", n_pl, 1);
			check("jump busy", n_busy, 4);
			check("jump target", pc_target, 21'(pc_in + {{9{offs[i][10]}}, offs[i], 1'b0}));
			check("jump mem", n_rd + n_wr, 0);
		end
	endtask : t_jump

	initial begin
		#20000;
		errors++;
		stop_test();
	end

	initial begin
		srst = 1'b1;
		instr = 16'h0000;
		next_words = 2'h1;
		pc_in = 21'h001000;
		bank_choice_value = 6'h05;
		ext_set_en = 1'b0;
		index_base = 14'h0100;
		errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		#1;
		srst = 1'b0;
		t_set_bank();
		t_skip();
		t_jump();
		stop_test();
	end
endmodule : bit_set_skip_branch_exec_tb
`default_nettype wire

// ==== dv/regfile_model.sv ====
// Data register file model for the bit execution block.
// Assumes reads are answered in the same clock as rd and writes land on the clock edge.
`timescale 1ns/1ns
`default_nettype none

module regfile_model (
	// Clock
	input  wire logic                    clk,
	// Register port
	input  wire bit_exec_pkg::data_req_t data_req,
	output logic [7:0]                   rd_data
);
	logic [7:0] mem [0:16383];

	// Outside a read the data shows the inverse, so a stale byte never looks valid.
	assign rd_data = data_req.rd ? mem[data_req.addr] : ~mem[data_req.addr];

	always @(posedge clk) begin
		if (data_req.wr) begin
			mem[data_req.addr] <= data_req.wdata;
		end
	end
endmodule : regfile_model
`default_nettype wire

// ==== rtl/bit_exec_defs.svh ====
// Constants for the bit set, bit test/skip and relative jump execution block.
// Assumes a 16-bit instruction word, an 8-bit data path and a byte-addressed program counter.
`ifndef BIT_EXEC_DEFS_SVH
`define BIT_EXEC_DEFS_SVH

`define OPC_SET_BIT     4'h8
`define OPC_TEST_ZERO   4'hB
`define OPC_REL_JUMP    5'h1A
`define IDX_LIMIT       8'h5F
`define ACCESS_BANK     6'h00
`define ACC_SPLIT       8'h60
`define HIGH_ACC_BANK   6'h3F
`define WORD_STEP       2'h2

`endif

// ==== rtl/bit_exec_pkg.sv ====
// Types shared by the bit execution block and its phase generator.
// Assumes bit_exec_defs.svh is included by each user.
package bit_exec_pkg;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} phase_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_SET,
		OP_TEST,
		OP_JUMP
	} op_t;

	typedef struct packed {
		logic [13:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
		logic        indexed;
	} data_req_t;

endpackage : bit_exec_pkg

// ==== rtl/bit_set_skip_branch_exec.sv ====
// Execution of bit set, bit test with skip when zero, and unconditional relative jump.
// Assumes the fetch path presents the instruction at Q1 and the register file answers a
// read within the same phase Q2 on rd_data; pc_in is the already-incremented counter.
// Operation
// - Opcode 1000 sets the chosen bit: read in Q2, write back in Q4.
// - Access flag 0 picks the shared bank; 1 uses the bank choice value.
// - Flag 0, extended set on, address at most 95: indexed literal offset.
// - Opcode 1011 tests a bit; zero means skip the next instruction.
// - A skip discards the fetched word and adds one no-operation cycle per word of the skipped instruction.
// - Skipping a two-word instruction costs three cycles in total.
// - Skipping a three-word instruction costs four cycles in total.
// - Jump: decode, read literal, process, load counter, then one idle cycle.
// - Jump encoding 11010 plus 11-bit offset; target is counter plus twice offset.
`timescale 1ns/1ns
`default_nettype none
`include "bit_exec_defs.svh"

module bit_set_skip_branch_exec #(
	parameter int PC_W = 21
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// Fetch path
	input  wire logic [15:0]             instr,
	input  wire logic [1:0]              next_words,
	input  wire logic [PC_W-1:0]         pc_in,
	output logic                         discard_fetch,
	output logic                         pc_load,
	output logic [PC_W-1:0]              pc_target,
	output logic                         busy,
	// Core state
	input  wire logic [5:0]              bank_choice_value,
	input  wire logic                    ext_set_en,
	input  wire logic [13:0]             index_base,
	// Register file
	output var  bit_exec_pkg::data_req_t data_req,
	input  wire logic [7:0]              rd_data,
	// Phase
	output var  bit_exec_pkg::phase_t    phase
);

	logic                   cycle_end;
	bit_exec_pkg::op_t      op_r;
	logic [15:0]            instr_r;
	logic [7:0]             val_r;
	logic [1:0]             nop_cnt_r;
	logic [PC_W-1:0]        target_r;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic bit_exec_pkg::op_t decode(input logic [15:0] w);
		if (w[15:12] == `OPC_SET_BIT)
			return bit_exec_pkg::OP_SET;
		else if (w[15:12] == `OPC_TEST_ZERO)
			return bit_exec_pkg::OP_TEST;
		else if (w[15:11] == `OPC_REL_JUMP)
			return bit_exec_pkg::OP_JUMP;
		else
			return bit_exec_pkg::OP_NONE;
	endfunction : decode

	function automatic logic [13:0] file_addr(input logic [15:0] w, input logic [5:0] bank,
			input logic ext, input logic [13:0] base);
		logic [7:0] f;
		f = w[7:0];
		if (!w[8] && ext && f <= `IDX_LIMIT)
			return 14'(base + {6'h00, f});
		else if (w[8])
			return {bank, f};
		else if (f < `ACC_SPLIT)
			return {`ACCESS_BANK, f};
		else
			return {`HIGH_ACC_BANK, f};
	endfunction : file_addr

	function automatic logic indexed(input logic [15:0] w, input logic ext);
		return !w[8] && ext && (w[7:0] <= `IDX_LIMIT);
	endfunction : indexed

	quad_phase u_phase (
		.clk       (clk),
		.srst      (srst),
		.phase     (phase),
		.cycle_end (cycle_end)
	);

	// ------------------------------------------------------------
	// Decode in Q1
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			op_r    <= bit_exec_pkg::OP_NONE;
			instr_r <= 16'h0000;
		end else if (phase == bit_exec_pkg::PH_Q1) begin
			if (nop_cnt_r != 2'h0) begin
				op_r <= bit_exec_pkg::OP_NONE;
			end else begin
				op_r    <= decode(instr);
				instr_r <= instr;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read in Q2, bit processing in Q3
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			val_r <= 8'h00;
		end else if (phase == bit_exec_pkg::PH_Q2) begin
			val_r <= rd_data;
		end else if (phase == bit_exec_pkg::PH_Q3 && op_r == bit_exec_pkg::OP_SET) begin
			val_r <= val_r | (8'h01 << instr_r[11:9]);
		end
	end

	always_comb begin
		data_req       = '0;
		data_req.addr  = file_addr(instr_r, bank_choice_value, ext_set_en, index_base);
		data_req.indexed = indexed(instr_r, ext_set_en);
		data_req.wdata = val_r;
		data_req.rd    = (phase == bit_exec_pkg::PH_Q2) &&
			(op_r == bit_exec_pkg::OP_SET || op_r == bit_exec_pkg::OP_TEST);
		data_req.wr    = (phase == bit_exec_pkg::PH_Q4) && (op_r == bit_exec_pkg::OP_SET);
	end

	// ------------------------------------------------------------
	// Jump target in Q3, counter load in Q4
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			target_r <= '0;
		end else if (phase == bit_exec_pkg::PH_Q3 && op_r == bit_exec_pkg::OP_JUMP) begin
			target_r <= pc_in + PC_W'({{(PC_W-11){instr_r[10]}}, instr_r[10:0]} << 1);
		end
	end

	assign pc_load   = (phase == bit_exec_pkg::PH_Q4) && (op_r == bit_exec_pkg::OP_JUMP);
	assign pc_target = target_r;

	// ------------------------------------------------------------
	// Idle cycles after a jump or a skip
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			nop_cnt_r <= 2'h0;
		end else if (cycle_end) begin
			if (op_r == bit_exec_pkg::OP_JUMP)
				nop_cnt_r <= 2'h1;
			else if (op_r == bit_exec_pkg::OP_TEST && !val_r[instr_r[11:9]])
				nop_cnt_r <= (next_words == 2'h0) ? 2'h1 : next_words;
			else if (nop_cnt_r != 2'h0)
				nop_cnt_r <= nop_cnt_r - 2'h1;
		end
	end

	assign discard_fetch = cycle_end && (op_r == bit_exec_pkg::OP_JUMP ||
		(op_r == bit_exec_pkg::OP_TEST && !val_r[instr_r[11:9]]));
	assign busy = (nop_cnt_r != 2'h0);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_set_q2;
		phase == bit_exec_pkg::PH_Q2 && op_r == bit_exec_pkg::OP_SET;
	endsequence

	sequence s_skip_end;
		cycle_end && op_r == bit_exec_pkg::OP_TEST && !val_r[instr_r[11:9]];
	endsequence

	chk_set_write_q4: assert property (@(posedge clk) disable iff (srst)
		s_set_q2 |-> ##2 (data_req.wr && data_req.wdata[instr_r[11:9]]))
		else $error("bit set did not write the bit in Q4");

	chk_set_keeps_bits: assert property (@(posedge clk) disable iff (srst)
		s_set_q2 |=> ##1 ((data_req.wdata | (8'h01 << instr_r[11:9])) ==
			($past(rd_data, 2) | (8'h01 << instr_r[11:9]))))
		else $error("bit set disturbed other bits");

	chk_bank_select: assert property (@(posedge clk) disable iff (srst)
		(data_req.rd && instr_r[8]) |-> data_req.addr[13:8] == bank_choice_value)
		else $error("banked access ignored the bank choice value");

	chk_indexed_mode: assert property (@(posedge clk) disable iff (srst)
		(data_req.rd && !instr_r[8] && ext_set_en && instr_r[7:0] <= `IDX_LIMIT) |->
			(data_req.indexed && data_req.addr == 14'(index_base + {6'h00, instr_r[7:0]})))
		else $error("indexed literal offset not applied");

	chk_no_skip_set: assert property (@(posedge clk) disable iff (srst)
		(cycle_end && op_r == bit_exec_pkg::OP_TEST && val_r[instr_r[11:9]]) |-> !discard_fetch)
		else $error("skip taken on a set bit");

	chk_skip_one: assert property (@(posedge clk) disable iff (srst)
		(s_skip_end and next_words <= 2'h1) |=> busy [*4] ##1 !busy)
		else $error("single skip length wrong");

	chk_skip_two: assert property (@(posedge clk) disable iff (srst)
		(s_skip_end and next_words == 2'h2) |=> busy [*8] ##1 !busy)
		else $error("two-word skip length wrong");

	chk_skip_three: assert property (@(posedge clk) disable iff (srst)
		(s_skip_end and next_words == 2'h3) |=> busy [*8] ##1 busy [*4] ##1 !busy)
		else $error("three-word skip length wrong");

	chk_jump_timing: assert property (@(posedge clk) disable iff (srst)
		pc_load |=> busy [*4] ##1 (!busy && !pc_load))
		else $error("jump idle cycle wrong");

	chk_jump_target: assert property (@(posedge clk) disable iff (srst)
		pc_load |-> pc_target == PC_W'($past(pc_in) +
			PC_W'({{(PC_W-11){instr_r[10]}}, instr_r[10:0]} << 1)))
		else $error("jump target wrong");

endmodule : bit_set_skip_branch_exec

`default_nettype wire

// ==== rtl/quad_phase.sv ====
// Four-phase generator: one clock cycle per phase, four phases per instruction cycle.
// Assumes a free-running clock and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module quad_phase (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Phase outputs
	output var  bit_exec_pkg::phase_t phase,
	output logic                  cycle_end
);

	always_ff @(posedge clk) begin
		if (srst) begin
			phase <= bit_exec_pkg::PH_Q1;
		end else begin
			unique case (phase)
				bit_exec_pkg::PH_Q1: phase <= bit_exec_pkg::PH_Q2;
				bit_exec_pkg::PH_Q2: phase <= bit_exec_pkg::PH_Q3;
				bit_exec_pkg::PH_Q3: phase <= bit_exec_pkg::PH_Q4;
				bit_exec_pkg::PH_Q4: phase <= bit_exec_pkg::PH_Q1;
			endcase
		end
	end

	assign cycle_end = (phase == bit_exec_pkg::PH_Q4);

endmodule : quad_phase

`default_nettype wire
